// ### common/exec_pkg.sv
// constants and types for the rotate/subtract/swap/xor/sleep execution unit
// assumes one core clock; status bit positions follow the usual status byte layout
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int NIB_W = 4;
  localparam int WDT_W = 8;
  localparam int PRE_W = 8;

  // apb register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_WDT = 8'h0C;
  localparam logic [7:0] OFF_RESULT = 8'h10;

  // status bits
  localparam int ST_CARRY = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PDN_N = 3;
  localparam int ST_TMO_N = 4;
  localparam logic [7:0] STATUS_RST = 8'h18;

  // control word fields: [2:0] opcode, [3] dest, [10:4] file addr, [23:16] literal/file value
  localparam int CTL_OP_LSB = 0;
  localparam int CTL_DST = 3;
  localparam int CTL_FA_LSB = 4;
  localparam int CTL_OPND_LSB = 16;

  typedef enum logic [2:0] {
    OP_ROT_R  = 3'h0,
    OP_ROT_L  = 3'h1,
    OP_SUB_L  = 3'h2,
    OP_SUB_F  = 3'h3,
    OP_SWAP   = 3'h4,
    OP_XOR_L  = 3'h5,
    OP_XOR_F  = 3'h6,
    OP_SLEEP  = 3'h7
  } op_t;

  typedef struct packed {
    logic [DATA_W-1:0]  data;
    logic [FADDR_W-1:0] addr;
    logic               we;
  } file_wr_t;
endpackage : exec_pkg

// ### hdl/exec_unit.sv
// execution unit for rotate, subtract, nibble swap, xor and sleep
// assumes apb master on core_clk; file operand is supplied in the control word
//
// Operation
// - dest bit picks accumulator or file for file operations; literal ops always write the accumulator
// - rotate right through carry
// - rotate left through carry
// - sleep clears watchdog counter and prescaler
// - sleep clears powerdown, sets timeout status
// - sleep halts main oscillator
// - literal minus accumulator with borrow flags
// - file minus accumulator with borrow flags
// - nibble exchange, no flags
// - literal xor accumulator, zero flag only
// - file xor accumulator, zero flag only
`timescale 1ns/10ps
module exec_unit #(
  parameter int DATA_W = exec_pkg::DATA_W,
  parameter int NIB_W  = exec_pkg::NIB_W
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  output exec_pkg::file_wr_t        file_wr,
  output logic                      osc_halt,
  output logic                      wdt_clear
);
  localparam int W = DATA_W;
  localparam int N = NIB_W;

  // the file write struct and the read mux are built for one byte of two nibbles
  if (DATA_W != exec_pkg::DATA_W || DATA_W != 2 * NIB_W) begin : g_width_check
    $error("exec_unit: data width must be the package width and two nibbles");
  end

  logic [W-1:0]              acc;
  logic [7:0]                status;
  logic [exec_pkg::WDT_W-1:0] wdt;
  logic [exec_pkg::PRE_W-1:0] wdt_pre;
  logic [W-1:0]              last_result;

  // apb decode
  wire acc_phase = psel & penable;
  wire wr_ctrl   = acc_phase & pwrite & (paddr == exec_pkg::OFF_CTRL);
  wire wr_acc    = acc_phase & pwrite & (paddr == exec_pkg::OFF_ACC);
  wire hit       = (paddr == exec_pkg::OFF_CTRL) | (paddr == exec_pkg::OFF_ACC)
                 | (paddr == exec_pkg::OFF_STATUS) | (paddr == exec_pkg::OFF_WDT)
                 | (paddr == exec_pkg::OFF_RESULT);

  // instruction fields
  wire exec_pkg::op_t        op    = exec_pkg::op_t'(pwdata[exec_pkg::CTL_OP_LSB +: 3]);
  wire                       dst   = pwdata[exec_pkg::CTL_DST];
  wire [exec_pkg::FADDR_W-1:0] faddr = pwdata[exec_pkg::CTL_FA_LSB +: exec_pkg::FADDR_W];
  wire [W-1:0]               opnd  = pwdata[exec_pkg::CTL_OPND_LSB +: W];
  wire                       c_old = status[exec_pkg::ST_CARRY];

  // subtraction: opnd - acc, carry is the inverse of borrow
  wire [W:0]   sub_full = {1'b0, opnd} + {1'b0, ~acc} + {{W{1'b0}}, 1'b1};
  wire [N:0]   sub_nib  = {1'b0, opnd[N-1:0]} + {1'b0, ~acc[N-1:0]} + {{N{1'b0}}, 1'b1};

  logic [W-1:0] res;
  logic         to_file;
  logic         upd_c;
  logic         upd_dc;
  logic         upd_z;
  logic         new_c;

  always_comb begin
    res     = opnd;
    to_file = 1'b0;
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    upd_z   = 1'b0;
    new_c   = c_old;
    case (op)
      exec_pkg::OP_ROT_R: begin
        res     = {c_old, opnd[W-1:1]};
        new_c   = opnd[0];
        upd_c   = 1'b1;
        to_file = dst;
      end
      exec_pkg::OP_ROT_L: begin
        res     = {opnd[W-2:0], c_old};
        new_c   = opnd[W-1];
        upd_c   = 1'b1;
        to_file = dst;
      end
      exec_pkg::OP_SUB_L: begin
        res     = sub_full[W-1:0];
        new_c   = sub_full[W];
        upd_c   = 1'b1;
        upd_dc  = 1'b1;
        upd_z   = 1'b1;
      end
      exec_pkg::OP_SUB_F: begin
        res     = sub_full[W-1:0];
        new_c   = sub_full[W];
        upd_c   = 1'b1;
        upd_dc  = 1'b1;
        upd_z   = 1'b1;
        to_file = dst;
      end
      exec_pkg::OP_SWAP: begin
        res     = {opnd[N-1:0], opnd[W-1:N]};
        to_file = dst;
      end
      exec_pkg::OP_XOR_L: begin
        res     = acc ^ opnd;
        upd_z   = 1'b1;
      end
      exec_pkg::OP_XOR_F: begin
        res     = acc ^ opnd;
        upd_z   = 1'b1;
        to_file = dst;
      end
      default: begin
        res     = acc;
      end
    endcase
  end

  wire is_sleep  = wr_ctrl & (op == exec_pkg::OP_SLEEP);
  wire writes_w  = wr_ctrl & ~is_sleep & ~to_file;

  logic [7:0] next_status;
  always_comb begin
    next_status = status;
    if (wr_ctrl && upd_c) begin
      next_status[exec_pkg::ST_CARRY] = new_c;
    end
    if (wr_ctrl && upd_dc) begin
      next_status[exec_pkg::ST_DIGIT] = sub_nib[N];
    end
    if (wr_ctrl && upd_z) begin
      next_status[exec_pkg::ST_ZERO] = (res == '0);
    end
    if (is_sleep) begin
      next_status[exec_pkg::ST_PDN_N] = 1'b0;
      next_status[exec_pkg::ST_TMO_N] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc         <= '0;
      status      <= exec_pkg::STATUS_RST;
      last_result <= '0;
    end else begin
      status <= next_status;
      if (wr_acc) begin
        acc <= pwdata[W-1:0];
      end else if (writes_w) begin
        acc <= res;
      end
      if (wr_ctrl && !is_sleep) begin
        last_result <= res;
      end
    end
  end

  // watchdog counter and prescaler stand-in, cleared by sleep
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdt       <= '0;
      wdt_pre   <= '0;
      wdt_clear <= 1'b0;
    end else begin
      wdt_clear <= is_sleep;
      if (is_sleep) begin
        wdt     <= '0;
        wdt_pre <= '0;
      end else if (!osc_halt) begin
        wdt_pre <= wdt_pre + 1'b1;
        if (wdt_pre == '1) begin
          wdt <= wdt + 1'b1;
        end
      end
    end
  end

  // halt stays until reset; wake-up is outside this block
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_halt <= 1'b0;
    end else if (is_sleep) begin
      osc_halt <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      file_wr <= '0;
    end else begin
      file_wr.we   <= wr_ctrl & ~is_sleep & to_file;
      file_wr.addr <= faddr;
      file_wr.data <= res;
    end
  end

  // apb: no wait state, answer registered in the setup cycle
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (paddr)
      exec_pkg::OFF_ACC:    rd_mux = {24'h000000, acc};
      exec_pkg::OFF_STATUS: rd_mux = {24'h000000, status};
      exec_pkg::OFF_WDT:    rd_mux = {16'h0000, wdt_pre, wdt};
      exec_pkg::OFF_RESULT: rd_mux = {24'h000000, last_result};
      default:              rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= rd_mux;
      pslverr <= psel & ~penable & ~hit;
    end
  end

  property p_sleep_flags;
    @(posedge core_clk) disable iff (rst)
      is_sleep |=> !status[exec_pkg::ST_PDN_N] && status[exec_pkg::ST_TMO_N];
  endproperty
  a_sleep_flags: assert property (p_sleep_flags) else $error("sleep status wrong");

  property p_sleep_wdt;
    @(posedge core_clk) disable iff (rst)
      is_sleep |=> wdt == '0 && wdt_pre == '0 && osc_halt;
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("sleep wdt not cleared");

  property p_halt_holds;
    @(posedge core_clk) disable iff (rst)
      osc_halt |=> osc_halt;
  endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("oscillator restarted");

  property p_rotr;
    @(posedge core_clk) disable iff (rst)
      (wr_ctrl && op == exec_pkg::OP_ROT_R) |=>
        last_result == {$past(c_old), $past(opnd[W-1:1])} && status[0] == $past(opnd[0]);
  endproperty
  a_rotr: assert property (p_rotr) else $error("rotate right wrong");

  property p_rotl;
    @(posedge core_clk) disable iff (rst)
      (wr_ctrl && op == exec_pkg::OP_ROT_L) |=>
        last_result == {$past(opnd[W-2:0]), $past(c_old)} && status[0] == $past(opnd[W-1]);
  endproperty
  a_rotl: assert property (p_rotl) else $error("rotate left wrong");

  property p_sub_c;
    @(posedge core_clk) disable iff (rst)
      (wr_ctrl && (op == exec_pkg::OP_SUB_L || op == exec_pkg::OP_SUB_F)) |=>
        status[exec_pkg::ST_CARRY] == ($past(acc) <= $past(opnd))
        && status[exec_pkg::ST_DIGIT] == ($past(acc[N-1:0]) <= $past(opnd[N-1:0]));
  endproperty
  a_sub_c: assert property (p_sub_c) else $error("borrow flags wrong");

  property p_swap;
    @(posedge core_clk) disable iff (rst)
      (wr_ctrl && op == exec_pkg::OP_SWAP) |=>
        last_result == {$past(opnd[N-1:0]), $past(opnd[W-1:N])} && $stable(status);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  wire is_file_op = (op == exec_pkg::OP_ROT_R) | (op == exec_pkg::OP_ROT_L) | (op == exec_pkg::OP_SUB_F)
                  | (op == exec_pkg::OP_SWAP) | (op == exec_pkg::OP_XOR_F);

  sequence s_to_file;
    wr_ctrl && is_file_op && dst;
  endsequence

  sequence s_to_acc;
    wr_ctrl && !is_sleep && !(is_file_op && dst);
  endsequence

  property p_dest_file;
    @(posedge core_clk) disable iff (rst)
      s_to_file |=> file_wr.we && file_wr.addr == $past(faddr) && file_wr.data == last_result && $stable(acc);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file destination missed");

  property p_dest_acc;
    @(posedge core_clk) disable iff (rst)
      s_to_acc |=> !file_wr.we && acc == last_result;
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator destination missed");

  property p_xor_z;
    @(posedge core_clk) disable iff (rst)
      (wr_ctrl && (op == exec_pkg::OP_XOR_L || op == exec_pkg::OP_XOR_F)) |=>
        status[exec_pkg::ST_ZERO] == ($past(acc ^ opnd) == '0)
        && status[exec_pkg::ST_CARRY] == $past(status[exec_pkg::ST_CARRY]);
  endproperty
  a_xor_z: assert property (p_xor_z) else $error("xor zero flag wrong");

  property p_sub_res;
    @(posedge core_clk) disable iff (rst)
      (wr_ctrl && (op == exec_pkg::OP_SUB_L || op == exec_pkg::OP_SUB_F)) |=>
        last_result == W'($past(opnd) - $past(acc));
  endproperty
  a_sub_res: assert property (p_sub_res) else $error("subtract result wrong");

  property p_sub_z;
    @(posedge core_clk) disable iff (rst)
      (wr_ctrl && (op == exec_pkg::OP_SUB_L || op == exec_pkg::OP_SUB_F)) |=>
        status[exec_pkg::ST_ZERO] == ($past(opnd) == $past(acc));
  endproperty
  a_sub_z: assert property (p_sub_z) else $error("subtract zero flag wrong");

  property p_xor_res;
    @(posedge core_clk) disable iff (rst)
      (wr_ctrl && (op == exec_pkg::OP_XOR_L || op == exec_pkg::OP_XOR_F)) |=>
        last_result == ($past(acc) ^ $past(opnd))
        && status[exec_pkg::ST_DIGIT] == $past(status[exec_pkg::ST_DIGIT]);
  endproperty
  a_xor_res: assert property (p_xor_res) else $error("xor result wrong");

  property p_rot_flags;
    @(posedge core_clk) disable iff (rst)
      (wr_ctrl && (op == exec_pkg::OP_ROT_R || op == exec_pkg::OP_ROT_L)) |=>
        status[exec_pkg::ST_ZERO] == $past(status[exec_pkg::ST_ZERO])
        && status[exec_pkg::ST_DIGIT] == $past(status[exec_pkg::ST_DIGIT]);
  endproperty
  a_rot_flags: assert property (p_rot_flags) else $error("rotate touched other flags");

  property p_wdt_clear;
    @(posedge core_clk) disable iff (rst)
      is_sleep |=> wdt_clear;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog clear pulse missing");
endmodule : exec_unit

// ### verif/testbench.sv
// self-checking bench for the execution unit: apb tasks drive instruction scenarios
// assumes exec_unit answers apb on core_clk (250 MHz) and exec_pkg is compiled first
`timescale 1ns/10ps
module testbench;
  logic               core_clk;
  logic               rst;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic               pready;
  logic [31:0]        prdata;
  logic               pslverr;
  exec_pkg::file_wr_t file_wr;
  logic               osc_halt;
  logic               wdt_clear;
  exec_pkg::file_wr_t fw_last;
  logic [31:0]        rd;
  logic               err;
  int                 errors;
  int                 total_checks;
  int                 cycles;
  int                 fw_cnt;
  int                 clr_cnt;

  exec_unit DUT (
    .core_clk  (core_clk),
    .rst       (rst),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .pready    (pready),
    .prdata    (prdata),
    .pslverr   (pslverr),
    .file_wr   (file_wr),
    .osc_halt  (osc_halt),
    .wdt_clear (wdt_clear)
  );

  always #2 core_clk = ~core_clk;

  task give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // file writes and watchdog clears are pulses, counted at the falling edge where they are settled
  always @(negedge core_clk) begin
    cycles++;
    if (file_wr.we === 1'b1) begin
      fw_cnt++;
      fw_last = file_wr;
    end
    if (wdt_clear === 1'b1) clr_cnt++;
    if (cycles == 4000) begin
      errors++;
      give_verdict();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %08h expected %08h", $time, seen, exp);
    end
  endtask : chk

  // one transfer, then one idle cycle; results reach the accumulator at the end of the access phase
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task op(input logic [2:0] o, input logic dst, input logic [6:0] fa, input logic [7:0] v);
    apb(1'b1, exec_pkg::OFF_CTRL, {8'h00, v, 5'h00, fa, dst, o});
  endtask : op

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rd, exp);
  endtask : rchk

  task acc_st(input logic [7:0] acc, input logic [7:0] st);
    rchk(exec_pkg::OFF_ACC, {24'h000000, acc});
    rchk(exec_pkg::OFF_STATUS, {24'h000000, st});
  endtask : acc_st

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    fw_cnt = 0;
    clr_cnt = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    acc_st(8'h00, 8'h18);
    chk({31'h0, osc_halt}, 32'h0);
    op(3'h0, 1'b0, 7'h01, 8'h81);
    acc_st(8'h40, 8'h19);
    op(3'h0, 1'b0, 7'h01, 8'h02);
    acc_st(8'h81, 8'h18);
    // zero result of a rotate must leave the zero flag alone
    op(3'h1, 1'b1, 7'h7F, 8'h80);
    chk({16'h0, fw_last}, {16'h0, 8'h00, 7'h7F, 1'b1});
    acc_st(8'h81, 8'h19);
    op(3'h1, 1'b0, 7'h02, 8'h01);
    acc_st(8'h03, 8'h18);
    op(3'h2, 1'b0, 7'h00, 8'h03);
    acc_st(8'h00, 8'h1F);
    apb(1'b1, exec_pkg::OFF_ACC, 32'h00000011);
    op(3'h2, 1'b0, 7'h00, 8'h10);
    acc_st(8'hFF, 8'h18);
    apb(1'b1, exec_pkg::OFF_ACC, 32'h0000000F);
    op(3'h3, 1'b1, 7'h05, 8'h20);
    chk({16'h0, fw_last}, {16'h0, 8'h11, 7'h05, 1'b1});
    acc_st(8'h0F, 8'h19);
    op(3'h4, 1'b0, 7'h06, 8'hA5);
    acc_st(8'h5A, 8'h19);
    op(3'h5, 1'b0, 7'h00, 8'h5A);
    acc_st(8'h00, 8'h1D);
    op(3'h6, 1'b1, 7'h2A, 8'h3C);
    chk({16'h0, fw_last}, {16'h0, 8'h3C, 7'h2A, 1'b1});
    acc_st(8'h00, 8'h19);
    chk(fw_cnt, 32'd3);
    apb(1'b0, 8'h14, 32'h00000000);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, exec_pkg::OFF_STATUS, 32'h00000000);
    rchk(exec_pkg::OFF_STATUS, 32'h19);
    op(3'h7, 1'b0, 7'h00, 8'h00);
    repeat (2) @(posedge core_clk);
    chk(clr_cnt, 32'd1);
    chk({31'h0, osc_halt}, 32'h1);
    rchk(exec_pkg::OFF_STATUS, 32'h11);
    rchk(exec_pkg::OFF_WDT, 32'h0);
    give_verdict();
  end
endmodule : testbench
